/* File: tmrcc_regs.vh */
// Register indices, field positions, reset values and mode codes of the
// 8-bit timer/counter block. Included by the timer design file only.
`ifndef TMRCC_REGS_VH
`define TMRCC_REGS_VH

// Register indices on the plain register port.
`define TMRCC_ADDR_CTRL_A 3'h0
`define TMRCC_ADDR_CTRL_B 3'h1
`define TMRCC_ADDR_COUNT 3'h2
`define TMRCC_ADDR_CMP_A 3'h3
`define TMRCC_ADDR_CMP_B 3'h4
`define TMRCC_ADDR_MASK 3'h5
`define TMRCC_ADDR_FLAGS 3'h6

// Control A fields.
`define TMRCC_CA_ACT_A_HI 7
`define TMRCC_CA_ACT_A_LO 6
`define TMRCC_CA_ACT_B_HI 5
`define TMRCC_CA_ACT_B_LO 4
`define TMRCC_CA_WAVE_HI 1
`define TMRCC_CA_WAVE_LO 0
`define TMRCC_CA_RW_MASK 8'hF3

// Control B fields.
`define TMRCC_CB_FORCE_A 7
`define TMRCC_CB_FORCE_B 6
`define TMRCC_CB_WAVE_UP 3
`define TMRCC_CB_CS_HI 2
`define TMRCC_CB_CS_LO 0
`define TMRCC_CB_RW_MASK 8'h0F

// Mask and flag positions.
`define TMRCC_BIT_MATCH_B 3
`define TMRCC_BIT_MATCH_A 2
`define TMRCC_BIT_WRAP 1
`define TMRCC_IRQ_MASK 8'h0E

// Reset values.
`define TMRCC_RESET_CTRL 8'h00
`define TMRCC_RESET_MASK 8'h00
`define TMRCC_RESET_FLAGS 8'h00
`define TMRCC_RESET_VALUE 8'h00

// Wave mode codes.
`define TMRCC_MODE_NORMAL 3'h0
`define TMRCC_MODE_PC_FF 3'h1
`define TMRCC_MODE_CTC 3'h2
`define TMRCC_MODE_FAST_FF 3'h3
`define TMRCC_MODE_PC_CMP 3'h5
`define TMRCC_MODE_FAST_CMP 3'h7

// Count source codes.
`define TMRCC_CS_STOP 3'h0
`define TMRCC_CS_DIV1 3'h1
`define TMRCC_CS_DIV8 3'h2
`define TMRCC_CS_DIV64 3'h3
`define TMRCC_CS_DIV256 3'h4
`define TMRCC_CS_DIV1024 3'h5
`define TMRCC_CS_PIN_FALL 3'h6
`define TMRCC_CS_PIN_RISE 3'h7

// Prescaler taps as divider bit positions (divide by 8, 64, 256, 1024).
`define TMRCC_TAP_8 2
`define TMRCC_TAP_64 5
`define TMRCC_TAP_256 7
`define TMRCC_TAP_1024 9

`define TMRCC_TOP_MAX 8'hFF
`define TMRCC_BOTTOM 8'h00

`endif

/* File: tmrcc_timer.v */
// 8-bit timer/counter with prescaler, external count pin, two compare
// channels, wave outputs and compare/overflow flags.
// Assumes one clock, a plain register port and a CPU that reports the
// interrupt vector it executes by one-cycle acknowledge pulses.
`timescale 1ns/10ps
`default_nettype none
`include "tmrcc_regs.vh"

// Summary of operation
// - Force strobes act only in non-PWM wave modes.
// - Force strobe makes an immediate match on that channel's output.
// - Forced match sets no flag and never clears the counter.
// - Force strobes at bits 7 and 6 always read zero.
// - Reserved bits of control B, mask and flags read zero.
// - Control B bit 3 is the upper wave mode bit.
// - Count source codes: stop, divide by 1, 8, 64, 256, 1024.
// - Code 6 counts falling pin edges, code 7 rising pin edges.
// - Pin edges count even while the pin is driven as output.
// - Counter value is fully readable and writable.
// - A counter write blocks compare matches on the next tick.
// - Compare A value is compared continuously and drives flag/output.
// - Compare B value is compared continuously and drives flag/output.
// - Mask bit 3 enables the compare B interrupt.
// - Mask bit 2 enables the compare A interrupt.
// - Mask bit 1 enables the overflow interrupt.
// - Flag bit 3 sets on a compare B match.
// - Flag bit 2 sets on a compare A match.
// - Compare flags clear by vector acknowledge or by writing one.
// - Flag bit 1 sets on overflow, clears like the compare flags.
// - Normal mode tops at 0xFF, clear-on-match mode at compare A.
module tmrcc_timer (
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  input wire external_count_pin,
  input wire cpu_irq_enable,
  input wire ack_match_a,
  input wire ack_match_b,
  input wire ack_wrap,
  output wire irq_match_a,
  output wire irq_match_b,
  output wire irq_wrap,
  output reg wave_output_a,
  output reg wave_output_b,
  output reg wave_output_a_en,
  output reg wave_output_b_en
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function is_pwm;
    input [2:0] mode;
    begin
      is_pwm = (mode != `TMRCC_MODE_NORMAL) && (mode != `TMRCC_MODE_CTC);
    end
  endfunction

  // Non-PWM compare output action: 1 toggle, 2 clear, 3 set.
  function wave_act;
    input [1:0] act;
    input cur;
    begin
      case (act)
        2'h1: wave_act = ~cur;
        2'h2: wave_act = 1'b0;
        2'h3: wave_act = 1'b1;
        default: wave_act = cur;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [7:0] ctrl_a_reg;
  reg [3:0] ctrl_b_reg;
  reg [7:0] count_reg;
  reg [7:0] cmp_a_reg;
  reg [7:0] cmp_b_reg;
  reg [2:0] mask_reg;
  reg [2:0] flags_reg;
  reg [9:0] presc_reg;
  reg [9:0] presc_next;
  reg [2:0] pin_sync_reg;
  reg block_reg;
  reg dir_down_reg;

  wire wr_ctrl_a = reg_write && (reg_addr == `TMRCC_ADDR_CTRL_A);
  wire wr_ctrl_b = reg_write && (reg_addr == `TMRCC_ADDR_CTRL_B);
  wire wr_count = reg_write && (reg_addr == `TMRCC_ADDR_COUNT);
  wire wr_flags = reg_write && (reg_addr == `TMRCC_ADDR_FLAGS);

  wire [2:0] wave_mode = {ctrl_b_reg[`TMRCC_CB_WAVE_UP],
    ctrl_a_reg[`TMRCC_CA_WAVE_HI:`TMRCC_CA_WAVE_LO]};
  wire [2:0] cs = ctrl_b_reg[`TMRCC_CB_CS_HI:`TMRCC_CB_CS_LO];
  wire [1:0] act_a = ctrl_a_reg[`TMRCC_CA_ACT_A_HI:`TMRCC_CA_ACT_A_LO];
  wire [1:0] act_b = ctrl_a_reg[`TMRCC_CA_ACT_B_HI:`TMRCC_CA_ACT_B_LO];
  wire pwm = is_pwm(wave_mode);
  wire phase_mode = (wave_mode == `TMRCC_MODE_PC_FF) ||
    (wave_mode == `TMRCC_MODE_PC_CMP);
  wire top_cmp = wave_mode[2] || (wave_mode == `TMRCC_MODE_CTC);
  wire [7:0] top = top_cmp ? cmp_a_reg : `TMRCC_TOP_MAX;

  // ----------------------------------------------------------------
  // Count source
  // ----------------------------------------------------------------
  // The prescaler runs free, so the first prescaled tick after enabling
  // may come anywhere within one divider period.
  reg [9:0] presc_prev;
  reg tick;
  always @* begin
    presc_next = presc_reg + 10'h001;
    presc_prev = presc_reg;
    case (cs)
      `TMRCC_CS_DIV1: tick = 1'b1;
      `TMRCC_CS_DIV8: tick = &presc_prev[`TMRCC_TAP_8:0];
      `TMRCC_CS_DIV64: tick = &presc_prev[`TMRCC_TAP_64:0];
      `TMRCC_CS_DIV256: tick = &presc_prev[`TMRCC_TAP_256:0];
      `TMRCC_CS_DIV1024: tick = &presc_prev[`TMRCC_TAP_1024:0];
      `TMRCC_CS_PIN_FALL: tick = pin_sync_reg[2] & ~pin_sync_reg[1];
      `TMRCC_CS_PIN_RISE: tick = ~pin_sync_reg[2] & pin_sync_reg[1];
      default: tick = 1'b0;
    endcase
  end

  // The pin is sampled regardless of its direction, so software driving
  // the pin as an output still counts. Only stages two and three are
  // compared; stage one only feeds stage two.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      presc_reg <= 10'h000;
      pin_sync_reg <= 3'h0;
    end else if (clk_en) begin
      presc_reg <= presc_next;
      pin_sync_reg <= {pin_sync_reg[1:0], external_count_pin};
    end
  end

  // ----------------------------------------------------------------
  // Counter, compare and flags
  // ----------------------------------------------------------------
  wire match_a = tick && !block_reg && (count_reg == cmp_a_reg);
  wire match_b = tick && !block_reg && (count_reg == cmp_b_reg);
  wire at_top = (count_reg == top);
  wire wrap_event = tick && (phase_mode ?
    (dir_down_reg && count_reg == `TMRCC_BOTTOM + 8'h01) ||
    (!dir_down_reg && count_reg == `TMRCC_BOTTOM && at_top) :
    (wave_mode == `TMRCC_MODE_FAST_CMP ? at_top :
     count_reg == `TMRCC_TOP_MAX));
  wire force_a = wr_ctrl_b && reg_wdata[`TMRCC_CB_FORCE_A] && !pwm;
  wire force_b = wr_ctrl_b && reg_wdata[`TMRCC_CB_FORCE_B] && !pwm;

  reg [7:0] count_next;
  reg dir_next;
  always @* begin
    count_next = count_reg;
    dir_next = dir_down_reg;
    if (wr_count) begin
      count_next = reg_wdata;
    end else if (tick) begin
      if (phase_mode) begin
        if (dir_down_reg) begin
          count_next = count_reg - 8'h01;
          if (count_reg == 8'h01) begin
            dir_next = 1'b0;
          end
        end else if (at_top) begin
          count_next = count_reg - 8'h01;
          dir_next = 1'b1;
        end else begin
          count_next = count_reg + 8'h01;
        end
      end else if (at_top && top_cmp) begin
        count_next = `TMRCC_BOTTOM;
      end else begin
        count_next = count_reg + 8'h01;
      end
    end
  end

  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_a_reg <= `TMRCC_RESET_CTRL;
      ctrl_b_reg <= 4'h0;
      count_reg <= `TMRCC_RESET_VALUE;
      cmp_a_reg <= `TMRCC_RESET_VALUE;
      cmp_b_reg <= `TMRCC_RESET_VALUE;
      mask_reg <= 3'h0;
      flags_reg <= 3'h0;
      block_reg <= 1'b0;
      dir_down_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl_a) begin
        ctrl_a_reg <= reg_wdata & `TMRCC_CA_RW_MASK;
      end
      if (wr_ctrl_b) begin
        ctrl_b_reg <= reg_wdata[3:0];
      end
      if (reg_write && reg_addr == `TMRCC_ADDR_CMP_A) begin
        cmp_a_reg <= reg_wdata;
      end
      if (reg_write && reg_addr == `TMRCC_ADDR_CMP_B) begin
        cmp_b_reg <= reg_wdata;
      end
      if (reg_write && reg_addr == `TMRCC_ADDR_MASK) begin
        mask_reg <= reg_wdata[3:1];
      end
      count_reg <= count_next;
      dir_down_reg <= dir_next;
      // The block stands from the counter write until the next tick.
      if (wr_count) begin
        block_reg <= 1'b1;
      end else if (tick) begin
        block_reg <= 1'b0;
      end
      // A new event wins over a clear in the same cycle.
      flags_reg[2] <= match_b || (flags_reg[2] && !ack_match_b &&
        !(wr_flags && reg_wdata[`TMRCC_BIT_MATCH_B]));
      flags_reg[1] <= match_a || (flags_reg[1] && !ack_match_a &&
        !(wr_flags && reg_wdata[`TMRCC_BIT_MATCH_A]));
      flags_reg[0] <= wrap_event || (flags_reg[0] && !ack_wrap &&
        !(wr_flags && reg_wdata[`TMRCC_BIT_WRAP]));
    end
  end

  // Forced matches drive only the wave outputs, never flags or counter.
  assign irq_match_b = cpu_irq_enable & mask_reg[2] & flags_reg[2];
  assign irq_match_a = cpu_irq_enable & mask_reg[1] & flags_reg[1];
  assign irq_wrap = cpu_irq_enable & mask_reg[0] & flags_reg[0];

  // ----------------------------------------------------------------
  // Wave outputs
  // ----------------------------------------------------------------
  // PWM output actions beyond plain set and clear are kept simple:
  // code 2 clears on up-count match and sets at top in fast modes or on down-count match in phase modes, code 3 the reverse.
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wave_output_a <= 1'b0;
      wave_output_b <= 1'b0;
      wave_output_a_en <= 1'b0;
      wave_output_b_en <= 1'b0;
    end else if (clk_en) begin
      wave_output_a_en <= (act_a != 2'h0);
      wave_output_b_en <= (act_b != 2'h0);
      if (!pwm) begin
        if (match_a || force_a) begin
          wave_output_a <= wave_act(act_a, wave_output_a);
        end
        if (match_b || force_b) begin
          wave_output_b <= wave_act(act_b, wave_output_b);
        end
      end else begin
        if (match_a) begin
          wave_output_a <= (act_a == 2'h1 && wave_mode[2]) ?
            ~wave_output_a : act_a[0] ^ dir_down_reg;
        end else if (tick && at_top && !phase_mode && act_a[1]) begin
          wave_output_a <= ~act_a[0];
        end
        if (match_b) begin
          wave_output_b <= act_b[0] ^ dir_down_reg;
        end else if (tick && at_top && !phase_mode && act_b[1]) begin
          wave_output_b <= ~act_b[0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_read) begin
        case (reg_addr)
          `TMRCC_ADDR_CTRL_A: reg_rdata <= ctrl_a_reg;
          `TMRCC_ADDR_CTRL_B: reg_rdata <= {4'h0, ctrl_b_reg};
          `TMRCC_ADDR_COUNT: reg_rdata <= count_reg;
          `TMRCC_ADDR_CMP_A: reg_rdata <= cmp_a_reg;
          `TMRCC_ADDR_CMP_B: reg_rdata <= cmp_b_reg;
          `TMRCC_ADDR_MASK: reg_rdata <= {4'h0, mask_reg, 1'b0};
          `TMRCC_ADDR_FLAGS: reg_rdata <= {4'h0, flags_reg, 1'b0};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* File: tmrcc_assertions.sv */
// Checker for the timer register port and interrupt outputs.
// Bound to the timer top module; sees only its ports, clock enable high.
`timescale 1ns/10ps
`default_nettype none
module tmrcc_assertions (
  input wire ref_clk,
  input wire reset,
  input wire [2:0] reg_addr,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire cpu_irq_enable,
  input wire irq_match_a,
  input wire irq_match_b,
  input wire irq_wrap
);
  // ------------------------
  // Read tracking and checks
  // ------------------------
  reg rd_hit;
  reg [2:0] rd_addr;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rd_hit <= 1'b0;
      rd_addr <= 3'h0;
    end else begin
      rd_hit <= reg_read;
      rd_addr <= reg_addr;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_rdata_idle: assert property (!rd_hit |-> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_force_zero: assert property (rd_hit && rd_addr == 3'h1
    |-> reg_rdata[7:6] == 2'h0) else $error("force strobe read back");
  a_ctrlb_rsvd: assert property (rd_hit && rd_addr == 3'h1
    |-> reg_rdata[5:4] == 2'h0) else $error("control b reserved set");
  a_mask_rsvd: assert property (rd_hit && rd_addr == 3'h5
    |-> reg_rdata[7:4] == 4'h0 && !reg_rdata[0])
    else $error("mask reserved set");
  a_flags_rsvd: assert property (rd_hit && rd_addr == 3'h6
    |-> reg_rdata[7:4] == 4'h0 && !reg_rdata[0])
    else $error("flags reserved set");
  a_irq_a_gate: assert property (irq_match_a |-> cpu_irq_enable)
    else $error("match a request without enable");
  a_irq_b_gate: assert property (irq_match_b |-> cpu_irq_enable)
    else $error("match b request without enable");
  a_irq_wrap_off: assert property ($fell(cpu_irq_enable)
    |-> !irq_wrap) else $error("wrap request without enable");
  cover property (irq_match_a && irq_match_b);
  cover property (irq_wrap);
  cover property (rd_hit && rd_addr == 3'h6 && reg_rdata != 8'h00);
endmodule
`default_nettype wire

/* File: tmrcc_timer_test.sv */
// Self-checking bench for the timer/counter block.
// Drives the register port and pins itself; one 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module tmrcc_timer_test;
  // ------------------
  // Signals and design
  // ------------------
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic external_count_pin = 1'b0;
  logic cpu_irq_enable = 1'b0;
  logic ack_match_a = 1'b0;
  logic ack_match_b = 1'b0;
  logic ack_wrap = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] v1;
  logic [7:0] v2;
  wire [7:0] reg_rdata;
  wire irq_match_a, irq_match_b, irq_wrap;
  wire wave_output_a, wave_output_b, wave_output_a_en, wave_output_b_en;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  tmrcc_timer tmrcc_timer_inst (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata),
    .external_count_pin(external_count_pin),
    .cpu_irq_enable(cpu_irq_enable), .ack_match_a(ack_match_a),
    .ack_match_b(ack_match_b), .ack_wrap(ack_wrap),
    .irq_match_a(irq_match_a), .irq_match_b(irq_match_b),
    .irq_wrap(irq_wrap), .wave_output_a(wave_output_a),
    .wave_output_b(wave_output_b), .wave_output_a_en(wave_output_a_en),
    .wave_output_b_en(wave_output_b_en)
  );
  always #12.5 ref_clk = ~ref_clk;
  // The whole run needs about 3000 cycles.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      final_report;
    end
  end
  // ----------
  // Bus tasks
  // ----------
  task automatic check(string n, logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(string n, logic [2:0] a, logic [7:0] m, logic [7:0] e);
    rd(a, v1);
    check(n, v1 & m, e);
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    s <= 1'b1;
    @(posedge ref_clk);
    s <= 1'b0;
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic t_regs;
    for (int a = 0; a < 8; a++) rdc("reset", a[2:0], 8'hFF, 8'h00);
    wr(3'h1, 8'h38);
    rdc("control_b", 3'h1, 8'hFF, 8'h08);
    wr(3'h1, 8'hC0);
    rdc("force read", 3'h1, 8'hFF, 8'h00);
    wr(3'h5, 8'hFF);
    rdc("mask", 3'h5, 8'hFF, 8'h0E);
    wr(3'h2, 8'hA5);
    rdc("count", 3'h2, 8'hFF, 8'hA5);
    repeat (20) @(posedge ref_clk);
    rdc("count hold", 3'h2, 8'hFF, 8'hA5);
  endtask
  task automatic t_sources;
    int div[5] = '{1, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      wr(3'h1, 8'h01 + i[7:0]);
      rd(3'h2, v2);
      // Two prescaler periods between the two reads give two ticks.
      repeat (2 * div[i] - 2) @(posedge ref_clk);
      rdc("count step", 3'h2, 8'hFF, v2 + 8'h02);
    end
    for (int m = 6; m < 8; m++) begin
      wr(3'h1, m[7:0]);
      rd(3'h2, v2);
      repeat (6) begin
        repeat (4) @(posedge ref_clk);
        external_count_pin <= ~external_count_pin;
      end
      repeat (6) @(posedge ref_clk);
      rdc("pin count", 3'h2, 8'hFF, v2 + 8'h03);
    end
    wr(3'h1, 8'h00);
  endtask
  task automatic t_match;
    wr(3'h2, 8'h20);
    wr(3'h3, 8'h22);
    wr(3'h4, 8'h24);
    wr(3'h6, 8'hFF);
    wr(3'h5, 8'h0C);
    cpu_irq_enable <= 1'b1;
    wr(3'h1, 8'h01);
    repeat (8) @(posedge ref_clk);
    wr(3'h1, 8'h00);
    rdc("flag a", 3'h6, 8'h04, 8'h04);
    rdc("flag b", 3'h6, 8'h08, 8'h08);
    check("irq a", {7'h0, irq_match_a}, 8'h01);
    check("irq b", {7'h0, irq_match_b}, 8'h01);
    @(posedge ref_clk);
    cpu_irq_enable <= 1'b0;
    #1 check("irq a off", {7'h0, irq_match_a}, 8'h00);
    cpu_irq_enable <= 1'b1;
    wr(3'h6, 8'h00);
    rdc("flags kept", 3'h6, 8'hFF, 8'h0C);
    pulse(ack_match_b);
    rdc("ack b", 3'h6, 8'hFF, 8'h04);
    wr(3'h6, 8'h04);
    rdc("clear a", 3'h6, 8'hFF, 8'h00);
    wr(3'h3, 8'h50);
    wr(3'h1, 8'h01);
    wr(3'h2, 8'h50);
    repeat (4) @(posedge ref_clk);
    wr(3'h1, 8'h00);
    rdc("blocked", 3'h6, 8'h04, 8'h00);
    wr(3'h5, 8'h02);
    wr(3'h2, 8'hFD);
    wr(3'h1, 8'h01);
    repeat (8) @(posedge ref_clk);
    wr(3'h1, 8'h00);
    rdc("wrap", 3'h6, 8'h02, 8'h02);
    check("irq wrap", {7'h0, irq_wrap}, 8'h01);
    pulse(ack_wrap);
    rdc("ack wrap", 3'h6, 8'h02, 8'h00);
  endtask
  task automatic t_force;
    wr(3'h6, 8'hFF);
    wr(3'h5, 8'h0C);
    wr(3'h0, 8'h52);
    wr(3'h2, 8'h10);
    #1 v2 = {6'h0, wave_output_b, wave_output_a};
    v1 = {6'h0, wave_output_b_en, wave_output_a_en};
    check("out enable", v1, 8'h03);
    wr(3'h1, 8'hC0);
    repeat (2) @(posedge ref_clk);
    #1 v1 = {6'h0, wave_output_b, wave_output_a};
    check("forced out", v1, v2 ^ 8'h03);
    rdc("forced flag", 3'h6, 8'hFF, 8'h00);
    rdc("forced count", 3'h2, 8'hFF, 8'h10);
    wr(3'h0, 8'h53);
    wr(3'h1, 8'h00);
    #1 v2 = {6'h0, wave_output_b, wave_output_a};
    // Deliberate strobe in a PWM mode, which the block must ignore.
    wr(3'h1, 8'hC0);
    repeat (2) @(posedge ref_clk);
    #1 v1 = {6'h0, wave_output_b, wave_output_a};
    check("pwm force", v1, v2);
  endtask
  task automatic final_report;
    if (err_total == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_sources;
    t_match;
    t_force;
    final_report;
  end
endmodule
bind tmrcc_timer tmrcc_assertions tmrcc_assertions_inst (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_rdata(reg_rdata),
  .cpu_irq_enable(cpu_irq_enable), .irq_match_a(irq_match_a),
  .irq_match_b(irq_match_b), .irq_wrap(irq_wrap)
);
`default_nettype wire
